// [rtl/poc_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Each emit command in the ready state gives one counted group
// - Group count accepts 1 through 4000
// - Count zero returns to continuous pulsing
// - Analog trigger starts groups only in group mode
// - Count query shows next group size, zero off
// - Emission on waits 3 s, then idles in group mode
// - Sync-over-group holds sync low whole group
// - Otherwise sync gives normal per-pulse low
// - Sync-over-group setting reads back
// - History holds first 50 energies after restart
// - History entry zero means no pulse yet
// - Suppression delay 50 to 400000 ns
// - Suppression delay zero disables suppression
// - Suppression delay reads back in ns
// - Energy adjust tunes current within 50 s
// - Adjust start carries energy, rate, save flag
// - Success adopts current and rate with internal trigger, reports current and energy
// - Failed adjustment reports a failure mark
module poc_top import poc_pkg::*; #(
	parameter longint SAFETY_CYC_P = SAFETY_CYC,
	parameter longint ADJ_CYC_P = ADJ_CYC,
	parameter int HIST_DEPTH = HIST_N
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic group_count_wr,
	input wire logic [GRP_W-1:0] group_count_val,
	input wire logic group_emit_cmd,
	input wire logic analog_group_trig,
	input wire logic sync_over_group_wr,
	input wire logic sync_over_group_val,
	input wire logic suppression_delay_wr,
	input wire logic [SUPP_W-1:0] suppression_delay_val,
	input wire logic emission_on_cmd,
	input wire logic emission_off_cmd,
	input wire logic external_emission_on_input,
	input wire logic rate_tick,
	input wire logic internal_trigger,
	input wire logic energy_valid,
	input wire logic [EN_W-1:0] energy_counts,
	input wire logic energy_history_query,
	input wire logic [HIST_AW-1:0] hist_idx,
	input wire logic auto_energy_adjust_command,
	input wire logic [EN_W-1:0] adj_energy,
	input wire logic [PRF_W-1:0] adj_prf,
	input wire logic adj_save,
	input wire logic thermal_stable,
	input wire logic pump_current_wr,
	input wire logic [CUR_W-1:0] pump_current_val,
	input wire logic rate_wr,
	input wire logic [PRF_W-1:0] rate_val,
	output logic laser_pulse_q,
	output logic sync_out_n_q,
	output logic emission_q,
	output logic [GRP_W-1:0] group_pulse_count_q,
	output logic sync_over_group_q,
	output logic [SUPP_W-1:0] suppression_delay_ns_q,
	output logic [EN_W-1:0] hist_data_q,
	output logic [CUR_W-1:0] pump_current_setting_q,
	output logic [PRF_W-1:0] repetition_rate_setting_q,
	output logic adj_busy_q,
	output logic adj_result_fail_q,
	output logic [CUR_W-1:0] adj_result_current_q,
	output logic [EN_W-1:0] adj_result_energy_q,
	output logic save_params_q
);
	poc_state_t state_q, state_d;
	logic [GRP_W-1:0] grp_d, remain_q, remain_d;
	logic sync_grp_d;
	logic [SUPP_W-1:0] supp_d;
	logic [TMR_W-1:0] tmr_q, tmr_d;
	logic [SUPP_W:0] ns_q, ns_d;
	logic [SYNC_W-1:0] sync_cnt_q, sync_cnt_d;
	logic ext_q;
	logic [CUR_W-1:0] cur_q, cur_d, pump_d;
	logic [PRF_W-1:0] prf_d;
	logic on_req, off_req, grp_req, fire, grp_start, sync_n_d;
	logic adj_busy, adj_done, adj_fail, adj_save_p;
	logic [CUR_W-1:0] adj_cur;
	logic [EN_W-1:0] adj_en;
	logic [PRF_W-1:0] adj_prf_q;

	poc_hist_if hist_bus();

	// External emission input acts on its edges, like the on and off commands
	assign on_req = emission_on_cmd | (external_emission_on_input & ~ext_q);
	assign off_req = emission_off_cmd | (~external_emission_on_input & ext_q);
	// Serial and analog requests only matter in the ready state of group mode
	assign grp_req = group_emit_cmd | analog_group_trig;

	// Settings written by the host; out-of-range values leave the old one
	always_comb begin
		grp_d = group_pulse_count_q;
		supp_d = suppression_delay_ns_q;
		sync_grp_d = sync_over_group_q;
		if (group_count_wr && group_count_val <= GRP_MAX) begin
			grp_d = group_count_val;
		end
		if (suppression_delay_wr && suppression_delay_val <= SUPP_MAX
		    && (suppression_delay_val >= SUPP_MIN || suppression_delay_val == SUPP_OFF)) begin
			supp_d = suppression_delay_val;
		end
		if (sync_over_group_wr) begin
			sync_grp_d = sync_over_group_val;
		end
	end

	// Emission sequencer: safety wait, ready, suppression hold-off, group, continuous
	always_comb begin
		state_d = state_q;
		tmr_d = tmr_q;
		ns_d = ns_q;
		remain_d = remain_q;
		fire = 1'b0;
		grp_start = 1'b0;
		case (state_q)
			ST_OFF: if (on_req) begin
				state_d = ST_ARM;
				tmr_d = '0;
			end
			ST_ARM: begin
				tmr_d = tmr_q + 1'b1;
				if (tmr_q == TMR_W'(SAFETY_CYC_P - 1)) begin
					state_d = (group_pulse_count_q == GRP_OFF) ? ST_CONT : ST_READY;
				end
			end
			ST_READY: if (group_pulse_count_q == GRP_OFF) begin
				state_d = ST_CONT;
			end else if (grp_req) begin
				grp_start = 1'b1;
				remain_d = group_pulse_count_q;
				ns_d = '0;
				state_d = (suppression_delay_ns_q == SUPP_OFF) ? ST_GROUP : ST_SUPP;
			end
			ST_SUPP: begin
				// Rate ticks inside the hold-off are dropped, taming the first pulse
				ns_d = ns_q + NS_STEP;
				if (ns_q >= {1'b0, suppression_delay_ns_q}) begin
					state_d = ST_GROUP;
				end
			end
			ST_GROUP: if (rate_tick) begin
				fire = 1'b1;
				remain_d = remain_q - 1'b1;
				if (remain_q == GRP_ONE) begin
					state_d = ST_READY;
				end
			end
			ST_CONT: begin
				fire = rate_tick;
				if (group_pulse_count_q != GRP_OFF) begin
					state_d = ST_READY;
				end
			end
			default: state_d = ST_OFF;
		endcase
		if (off_req) begin
			state_d = ST_OFF;
		end
	end

	// Sync output, active low: per-pulse stretch, or the whole group
	always_comb begin
		sync_cnt_d = (sync_cnt_q != '0) ? sync_cnt_q - 1'b1 : sync_cnt_q;
		if (fire) begin
			sync_cnt_d = SYNC_W'(SYNC_CYC - 1);
		end
		sync_n_d = !(fire || sync_cnt_q > SYNC_W'(1)
			|| (sync_over_group_q && state_d == ST_GROUP && state_q != ST_SUPP));
	end

	// Diode current and rate: host writes, or adopted after a good adjustment with internal trigger
	always_comb begin
		cur_d = cur_q;
		prf_d = repetition_rate_setting_q;
		if (pump_current_wr && !adj_busy) begin
			cur_d = pump_current_val;
		end
		if (rate_wr && !adj_busy) begin
			prf_d = rate_val;
		end
		if (adj_done && !adj_fail && internal_trigger) begin
			cur_d = adj_cur;
			prf_d = adj_prf_q;
		end
		pump_d = adj_busy ? adj_cur : cur_d;
	end

	// History restarts on emission on, group start and each read-out
	assign hist_bus.clr = on_req | grp_start | energy_history_query;
	assign hist_bus.wr = energy_valid && state_q != ST_OFF;
	// A zero reading would look like "no pulse", so it is lifted to one
	assign hist_bus.wdata = (energy_counts == EN_NONE) ? EN_LEAST : energy_counts;
	assign hist_bus.ridx = hist_idx;
	assign hist_data_q = hist_bus.rdata;

	poc_hist #(
		.DEPTH(HIST_DEPTH)
	) u_hist (
		.clk(clk),
		.rst(rst),
		.h(hist_bus.store)
	);

	poc_adjust #(
		.TIMEOUT_P(ADJ_CYC_P)
	) u_adjust (
		.clk(clk),
		.rst(rst),
		.start(auto_energy_adjust_command),
		.target(adj_energy),
		.prf(adj_prf),
		.save(adj_save),
		.emission(state_q != ST_OFF),
		.stable(thermal_stable),
		.sample_valid(energy_valid),
		.sample(energy_counts),
		.cur_init(cur_q),
		.busy_q(adj_busy),
		.done_q(adj_done),
		.fail_q(adj_fail),
		.cur_q(adj_cur),
		.en_q(adj_en),
		.prf_q(adj_prf_q),
		.save_q(adj_save_p)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ST_OFF;
			tmr_q <= '0;
			ns_q <= '0;
			remain_q <= GRP_OFF;
			sync_cnt_q <= '0;
			ext_q <= 1'b0;
			cur_q <= CUR_RST;
			laser_pulse_q <= 1'b0;
			sync_out_n_q <= 1'b1;
			emission_q <= 1'b0;
			group_pulse_count_q <= GRP_OFF;
			sync_over_group_q <= 1'b0;
			suppression_delay_ns_q <= SUPP_OFF;
			pump_current_setting_q <= CUR_RST;
			repetition_rate_setting_q <= PRF_RST;
			adj_busy_q <= 1'b0;
			adj_result_fail_q <= 1'b0;
			adj_result_current_q <= CUR_RST;
			adj_result_energy_q <= EN_NONE;
			save_params_q <= 1'b0;
		end else begin
			state_q <= state_d;
			tmr_q <= tmr_d;
			ns_q <= ns_d;
			remain_q <= remain_d;
			sync_cnt_q <= sync_cnt_d;
			ext_q <= external_emission_on_input;
			cur_q <= cur_d;
			laser_pulse_q <= fire;
			sync_out_n_q <= sync_n_d;
			emission_q <= (state_d != ST_OFF);
			group_pulse_count_q <= grp_d;
			sync_over_group_q <= sync_grp_d;
			suppression_delay_ns_q <= supp_d;
			pump_current_setting_q <= pump_d;
			repetition_rate_setting_q <= prf_d;
			adj_busy_q <= adj_busy;
			adj_result_fail_q <= adj_fail;
			adj_result_current_q <= adj_done && !adj_fail ? adj_cur : adj_result_current_q;
			adj_result_energy_q <= adj_done && !adj_fail ? adj_en : adj_result_energy_q;
			save_params_q <= adj_save_p;
		end
	end

	chk_count_write: assert property (@(posedge clk) disable iff (rst) group_count_wr && group_count_val <= GRP_MAX |=> group_pulse_count_q == $past(group_count_val)) else $error("group count not taken");
	chk_zero_count: assert property (@(posedge clk) disable iff (rst) state_q == ST_READY && group_pulse_count_q == GRP_OFF && !off_req |=> state_q == ST_CONT) else $error("zero count kept group mode");
	chk_group_load: assert property (@(posedge clk) disable iff (rst) grp_start |=> remain_q == $past(group_pulse_count_q)) else $error("group count not loaded");
	chk_group_pulse: assert property (@(posedge clk) disable iff (rst) state_q == ST_GROUP && rate_tick |=> laser_pulse_q ##1 (state_q != ST_ARM)) else $error("group tick gave no pulse");
	chk_safety_idle: assert property (@(posedge clk) disable iff (rst) $rose(emission_q) |-> !laser_pulse_q [*8]) else $error("pulse during safety wait");
	chk_sync_group: assert property (@(posedge clk) disable iff (rst) state_q == ST_GROUP && $past(state_q) == ST_GROUP && sync_over_group_q && $past(sync_over_group_q) |-> !sync_out_n_q) else $error("sync released inside group");
	chk_sync_pulse: assert property (@(posedge clk) disable iff (rst) laser_pulse_q |-> !sync_out_n_q) else $error("pulse without sync");
	chk_sync_readback: assert property (@(posedge clk) disable iff (rst) sync_over_group_wr |=> sync_over_group_q == $past(sync_over_group_val)) else $error("sync setting lost");
	chk_supp_holdoff: assert property (@(posedge clk) disable iff (rst) state_q == ST_SUPP |=> !laser_pulse_q) else $error("pulse inside hold-off");
	chk_supp_bypass: assert property (@(posedge clk) disable iff (rst) grp_start && suppression_delay_ns_q == SUPP_OFF && !off_req |=> state_q == ST_GROUP) else $error("zero delay still held off");
endmodule
`default_nettype wire

// [rtl/poc_pkg.sv]
package poc_pkg;
	// Clock period of the single system clock
	localparam int CLK_NS = 5;
	// Group pulse count: 0 means group mode off
	localparam int GRP_W = 12;
	localparam logic [GRP_W-1:0] GRP_OFF = 12'h000;
	localparam logic [GRP_W-1:0] GRP_ONE = 12'h001;
	localparam logic [GRP_W-1:0] GRP_MAX = 12'hFA0;
	// Suppression delay in ns: 0 means suppression off
	localparam int SUPP_W = 19;
	localparam logic [SUPP_W-1:0] SUPP_OFF = 19'h00000;
	localparam logic [SUPP_W-1:0] SUPP_MIN = 19'h00032;
	localparam logic [SUPP_W-1:0] SUPP_MAX = 19'h61A80;
	localparam logic [SUPP_W:0] NS_STEP = (SUPP_W + 1)'(CLK_NS);
	// Long times, in seconds, and their cycle counts
	localparam longint NS_PER_S = 1000000000;
	localparam longint SAFETY_S = 3;
	localparam longint ADJ_MAX_S = 50;
	localparam longint SAFETY_CYC = SAFETY_S * NS_PER_S / CLK_NS;
	localparam longint ADJ_CYC = ADJ_MAX_S * NS_PER_S / CLK_NS;
	localparam int TMR_W = 34;
	// Per-pulse sync low time, rounded up to cycles; sync holds low SYNC_CYC - 1 of them
	localparam int SYNC_NS = 100;
	localparam int SYNC_CYC = (SYNC_NS + CLK_NS - 1) / CLK_NS;
	localparam int SYNC_W = 8;
	// Energy history
	localparam int HIST_N = 50;
	localparam int HIST_AW = 6;
	localparam int EN_W = 16;
	localparam logic [EN_W-1:0] EN_NONE = 16'h0000;
	localparam logic [EN_W-1:0] EN_LEAST = 16'h0001;
	// Energy adjustment
	localparam int CUR_W = 16;
	localparam int PRF_W = 20;
	localparam logic [EN_W:0] EN_TOL = 17'h00010;
	localparam logic [CUR_W-1:0] CUR_STEP = 16'h0001;
	localparam logic [CUR_W-1:0] CUR_ZERO = 16'h0000;
	localparam logic [CUR_W-1:0] CUR_MAX = 16'hFFFF;
	localparam logic [CUR_W-1:0] CUR_RST = 16'h0000;
	localparam logic [PRF_W-1:0] PRF_RST = 20'h00000;

	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_ARM = 3'b001,
		ST_READY = 3'b011,
		ST_SUPP = 3'b010,
		ST_GROUP = 3'b110,
		ST_CONT = 3'b111
	} poc_state_t;

	typedef enum logic {
		ADJ_IDLE = 1'b0,
		ADJ_RUN = 1'b1
	} poc_adj_t;
endpackage

// [rtl/poc_hist_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface poc_hist_if import poc_pkg::*;;
	logic clr;
	logic wr;
	logic [EN_W-1:0] wdata;
	logic [HIST_AW-1:0] ridx;
	logic [EN_W-1:0] rdata;
	modport ctrl(output clr, output wr, output wdata, output ridx, input rdata);
	modport store(input clr, input wr, input wdata, input ridx, output rdata);
endinterface
`default_nettype wire

// [rtl/poc_hist.sv]
`timescale 1ns/1ps
`default_nettype none
// Holds the energies of the first pulses of a session
module poc_hist import poc_pkg::*; #(
	parameter int DEPTH = HIST_N
) (
	input wire logic clk,
	input wire logic rst,
	poc_hist_if.store h
);
	logic [EN_W-1:0] mem_q [DEPTH];
	logic [EN_W-1:0] mem_d [DEPTH];
	logic [HIST_AW-1:0] wptr_q, wptr_d;
	logic [EN_W-1:0] rdata_d;

	// Clear empties every entry; a write in the same cycle lands in entry 0
	always_comb begin
		wptr_d = h.clr ? '0 : wptr_q;
		for (int i = 0; i < DEPTH; i++) begin
			mem_d[i] = h.clr ? EN_NONE : mem_q[i];
		end
		if (h.wr && wptr_d < HIST_AW'(DEPTH)) begin
			mem_d[wptr_d] = h.wdata;
			wptr_d = wptr_d + 1'b1;
		end
		rdata_d = (h.ridx < HIST_AW'(DEPTH)) ? mem_q[h.ridx] : EN_NONE;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wptr_q <= '0;
			h.rdata <= EN_NONE;
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= EN_NONE;
			end
		end else begin
			wptr_q <= wptr_d;
			h.rdata <= rdata_d;
			mem_q <= mem_d;
		end
	end

	chk_hist_restart: assert property (@(posedge clk) disable iff (rst) h.clr && !h.wr |=> wptr_q == '0 && mem_q[0] == EN_NONE) else $error("history not cleared");
endmodule
`default_nettype wire

// [rtl/poc_adjust.sv]
`timescale 1ns/1ps
`default_nettype none
// Steps diode current until the measured energy meets the target
module poc_adjust import poc_pkg::*; #(
	parameter longint TIMEOUT_P = ADJ_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [EN_W-1:0] target,
	input wire logic [PRF_W-1:0] prf,
	input wire logic save,
	input wire logic emission,
	input wire logic stable,
	input wire logic sample_valid,
	input wire logic [EN_W-1:0] sample,
	input wire logic [CUR_W-1:0] cur_init,
	output logic busy_q,
	output logic done_q,
	output logic fail_q,
	output logic [CUR_W-1:0] cur_q,
	output logic [EN_W-1:0] en_q,
	output logic [PRF_W-1:0] prf_q,
	output logic save_q
);
	poc_adj_t st_q, st_d;
	logic [TMR_W-1:0] tmr_q, tmr_d;
	logic [EN_W-1:0] tgt_q, tgt_d, en_d;
	logic [CUR_W-1:0] cur_d;
	logic [PRF_W-1:0] prf_d;
	logic keep_q, keep_d, done_d, fail_d, save_d;

	// One current step per energy sample, so the run time follows the target
	always_comb begin
		st_d = st_q;
		tmr_d = tmr_q;
		tgt_d = tgt_q;
		en_d = en_q;
		cur_d = cur_q;
		prf_d = prf_q;
		keep_d = keep_q;
		fail_d = fail_q;
		done_d = 1'b0;
		save_d = 1'b0;
		case (st_q)
			ADJ_IDLE: if (start) begin
				done_d = !(emission && stable); // Refused without emission or thermal settle
				fail_d = !(emission && stable);
				st_d = (emission && stable) ? ADJ_RUN : ADJ_IDLE;
				tmr_d = '0;
				tgt_d = target;
				prf_d = prf;
				keep_d = save;
				cur_d = cur_init;
			end
			ADJ_RUN: begin
				tmr_d = tmr_q + 1'b1;
				if (!emission || tmr_q == TMR_W'(TIMEOUT_P - 1)) begin
					fail_d = 1'b1;
					done_d = 1'b1;
					st_d = ADJ_IDLE;
				end else if (sample_valid) begin
					if ({1'b0, sample} + EN_TOL < {1'b0, tgt_q}) begin
						fail_d = (cur_q == CUR_MAX);
						done_d = (cur_q == CUR_MAX);
						cur_d = (cur_q == CUR_MAX) ? cur_q : cur_q + CUR_STEP;
					end else if ({1'b0, sample} > {1'b0, tgt_q} + EN_TOL) begin
						fail_d = (cur_q == CUR_ZERO);
						done_d = (cur_q == CUR_ZERO);
						cur_d = (cur_q == CUR_ZERO) ? cur_q : cur_q - CUR_STEP;
					end else begin
						en_d = sample;
						done_d = 1'b1;
						save_d = keep_q;
					end
					st_d = (done_d) ? ADJ_IDLE : ADJ_RUN;
				end
			end
			default: st_d = ADJ_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= ADJ_IDLE;
			tmr_q <= '0;
			tgt_q <= EN_NONE;
			en_q <= EN_NONE;
			cur_q <= CUR_RST;
			prf_q <= PRF_RST;
			keep_q <= 1'b0;
			fail_q <= 1'b0;
			done_q <= 1'b0;
			save_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			tgt_q <= tgt_d;
			en_q <= en_d;
			cur_q <= cur_d;
			prf_q <= prf_d;
			keep_q <= keep_d;
			fail_q <= fail_d;
			done_q <= done_d;
			save_q <= save_d;
			busy_q <= (st_d == ADJ_RUN);
		end
	end

	chk_adjust_bounded: assert property (@(posedge clk) disable iff (rst) st_q == ADJ_RUN |-> tmr_q < TMR_W'(TIMEOUT_P)) else $error("adjustment overran its limit");
	chk_adjust_refused: assert property (@(posedge clk) disable iff (rst) st_q == ADJ_IDLE && start && !stable |=> done_q && fail_q) else $error("unsettled start not refused");
endmodule
`default_nettype wire

// [test/poc_host.sv]
`timescale 1ns/1ps
`default_nettype none
// Far side: rate ticks, pulse energy readings and the thermal settle flag
module poc_host import poc_pkg::*; #(
	parameter int GAP = 40,
	parameter int SETTLE = 100
) (
	input wire logic clk,
	input wire logic tick_en,
	input wire logic pulse,
	input wire logic emis,
	input wire logic [CUR_W-1:0] cur,
	output logic rate_tick,
	output logic energy_valid,
	output logic [EN_W-1:0] energy_counts,
	output logic thermal_stable
);
	int gap_q = 0;
	int settle_q = 0;
	logic [2:0] seq_q = 3'h0;
	// Outputs have one driver only; all but energy_counts settle at the first falling edge, well inside reset
	// Energy follows current plus a small per-pulse step; idle data is inverted
	always @(negedge clk) begin
		gap_q <= (gap_q == GAP - 1) ? 0 : gap_q + 1;
		rate_tick <= tick_en && gap_q == 0;
		energy_valid <= pulse;
		energy_counts <= pulse ? {cur[13:0], 2'b00} + 16'(seq_q) : ~energy_counts;
		seq_q <= !emis ? 3'h0 : seq_q + 3'(pulse);
		settle_q <= !emis ? 0 : settle_q + 1;
		thermal_stable <= emis && settle_q >= SETTLE;
	end
endmodule
`default_nettype wire

// [test/test_pulsed_output_control.sv]
`timescale 1ns/1ps
`default_nettype none
module test_pulsed_output_control import poc_pkg::*;;
	localparam int B_CNT = 0, B_EMIT = 1, B_ANA = 2, B_SYNC = 3, B_SUPP = 4, B_ON = 5;
	localparam int B_OFF = 6, B_QRY = 7, B_ADJ = 8, B_CUR = 9, B_RATE = 10;
	localparam logic [31:0] CNT_TAB [4] = '{32'h0, 32'h1, 32'hFA0, 32'hFA1};
	localparam logic [31:0] SUP_TAB [5] = '{32'h32, 32'h61A80, 32'h31, 32'h61A81, 32'h0};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [10:0] stb = 11'h000;
	logic [39:0] val = 40'h0;
	logic ext_on = 1'b0;
	logic tick_en = 1'b0;
	logic clr = 1'b0;
	logic int_trig = 1'b1;
	logic sync_prev = 1'b1;
	logic [HIST_AW-1:0] hist_idx = 6'h00;
	logic rate_tick, energy_valid, thermal_stable;
	logic [EN_W-1:0] energy_counts, hist_data_q, adj_result_energy_q;
	logic laser_pulse_q, sync_out_n_q, emission_q, sync_over_group_q;
	logic adj_busy_q, adj_result_fail_q, save_params_q;
	logic [GRP_W-1:0] group_pulse_count_q;
	logic [SUPP_W-1:0] suppression_delay_ns_q;
	logic [CUR_W-1:0] pump_current_setting_q, adj_result_current_q;
	logic [PRF_W-1:0] repetition_rate_setting_q;
	int err_total = 0, cmp_count = 0, pulses = 0, rises = 0, lows = 0;
	int ticks = 0, saves = 0, cyc = 0, first = 0;

	// Short safety wait and adjust limit keep the run brief
	poc_top #(.SAFETY_CYC_P(20), .ADJ_CYC_P(2000), .HIST_DEPTH(HIST_N)) poc_top_i (
		.clk, .rst, .group_count_wr(stb[B_CNT]), .group_count_val(val[GRP_W-1:0]),
		.group_emit_cmd(stb[B_EMIT]), .analog_group_trig(stb[B_ANA]),
		.sync_over_group_wr(stb[B_SYNC]), .sync_over_group_val(val[0]),
		.suppression_delay_wr(stb[B_SUPP]), .suppression_delay_val(val[SUPP_W-1:0]),
		.emission_on_cmd(stb[B_ON]), .emission_off_cmd(stb[B_OFF]),
		.external_emission_on_input(ext_on), .rate_tick, .internal_trigger(int_trig),
		.energy_valid, .energy_counts, .energy_history_query(stb[B_QRY]), .hist_idx,
		.auto_energy_adjust_command(stb[B_ADJ]), .adj_energy(val[15:0]),
		.adj_prf(val[35:16]), .adj_save(val[36]), .thermal_stable,
		.pump_current_wr(stb[B_CUR]), .pump_current_val(val[CUR_W-1:0]),
		.rate_wr(stb[B_RATE]), .rate_val(val[PRF_W-1:0]), .laser_pulse_q, .sync_out_n_q,
		.emission_q, .group_pulse_count_q, .sync_over_group_q, .suppression_delay_ns_q,
		.hist_data_q, .pump_current_setting_q, .repetition_rate_setting_q, .adj_busy_q,
		.adj_result_fail_q, .adj_result_current_q, .adj_result_energy_q, .save_params_q
	);
	poc_host poc_host_i (.clk, .tick_en, .pulse(laser_pulse_q), .emis(emission_q),
		.cur(pump_current_setting_q), .rate_tick, .energy_valid, .energy_counts,
		.thermal_stable);

	always #2.5 clk = ~clk;

	// Event counters, sampled at the falling edge where outputs are settled
	always @(negedge clk) begin
		cyc <= cyc + 1;
		sync_prev <= sync_out_n_q;
		pulses <= clr ? 0 : pulses + int'(laser_pulse_q);
		rises <= clr ? 0 : rises + int'(sync_out_n_q && !sync_prev);
		lows <= clr ? 0 : lows + int'(!sync_out_n_q);
		ticks <= clr ? 0 : ticks + int'(rate_tick);
		saves <= clr ? 0 : saves + int'(save_params_q);
		if (clr) first <= 0;
		else if (laser_pulse_q && first == 0) first <= cyc;
	end

	task automatic check_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s: got %0h exp %0h", $time, what, got, exp);
		end
	endtask
	task automatic check_in(input logic [31:0] got, input int lo, input int hi, input string what);
		cmp_count++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			err_total++;
			$display("[FAIL] %0t %s: got %0d", $time, what, got);
		end
	endtask
	// One strobe with its value, then two settle cycles for the readback
	task automatic cmd(input int b, input logic [39:0] v);
		@(negedge clk);
		val = v;
		stb[b] = 1'b1;
		@(negedge clk);
		stb = 11'h000;
		repeat (2) @(negedge clk);
	endtask
	task automatic clr_cnt();
		@(negedge clk);
		clr <= 1'b1;
		@(negedge clk);
		clr <= 1'b0;
	endtask
	// Start just after a tick so suppression visibly drops the next one
	task automatic align();
		for (int i = 0; i < 100 && rate_tick !== 1'b1; i++) @(negedge clk);
	endtask
	task automatic hist_chk(input int i, input logic [EN_W-1:0] exp);
		@(negedge clk);
		hist_idx = 6'(i);
		repeat (2) @(negedge clk);
		check_eq(32'(hist_data_q), 32'(exp), "history entry");
	endtask

	task automatic t_settings();
		logic [31:0] exp;
		check_eq(sync_out_n_q, 32'h1, "sync idle");
		check_eq(group_pulse_count_q, 32'h0, "count reset");
		exp = 32'h0;
		for (int i = 0; i < 4; i++) begin
			cmd(B_CNT, 40'(CNT_TAB[i]));
			if (CNT_TAB[i] <= 32'(GRP_MAX)) exp = CNT_TAB[i];
			check_eq(group_pulse_count_q, exp, "count readback");
		end
		for (int i = 0; i < 5; i++) begin
			cmd(B_SUPP, 40'(SUP_TAB[i]));
			if (SUP_TAB[i] == 32'h0 || (SUP_TAB[i] >= 32'(SUPP_MIN) &&
				SUP_TAB[i] <= 32'(SUPP_MAX))) exp = SUP_TAB[i];
			check_eq(suppression_delay_ns_q, exp, "delay readback");
		end
		for (int i = 1; i >= 0; i--) begin
			cmd(B_SYNC, 40'(i));
			check_eq(sync_over_group_q, 32'(i), "sync setting");
		end
		$display("settings test done");
	endtask

	task automatic t_group();
		int t0;
		cmd(B_CUR, 40'h64);
		cmd(B_CNT, 40'h3);
		tick_en <= 1'b1;
		clr_cnt();
		cmd(B_EMIT, 40'h0);
		cmd(B_ON, 40'h0);
		check_eq(emission_q, 32'h1, "emission on");
		cmd(B_EMIT, 40'h0);
		repeat (200) @(negedge clk);
		check_eq(pulses, 32'h0, "idle after on");
		align();
		t0 = cyc;
		cmd(B_EMIT, 40'h0);
		repeat (20) @(negedge clk);
		cmd(B_EMIT, 40'h0);
		repeat (200) @(negedge clk);
		check_eq(pulses, 32'h3, "group size");
		check_eq(rises, 32'h3, "sync per pulse");
		check_eq(lows, 32'(3 * (SYNC_CYC - 1)), "sync pulse span");
		check_in(first - t0, 1, 47, "undelayed start");
		check_eq(group_pulse_count_q, 32'h3, "next group size");
		for (int i = 0; i < 3; i++) hist_chk(i, 16'h0190 + 16'(i));
		hist_chk(3, EN_NONE);
		cmd(B_QRY, 40'h0);
		hist_chk(0, EN_NONE);
		$display("group test done");
	endtask

	task automatic t_analog();
		cmd(B_SYNC, 40'h1);
		clr_cnt();
		cmd(B_ANA, 40'h0);
		repeat (200) @(negedge clk);
		check_eq(pulses, 32'h3, "analog group");
		check_eq(rises, 32'h1, "sync over group");
		check_in(lows, 99, 145, "sync low span");
		cmd(B_SYNC, 40'h0);
		$display("analog test done");
	endtask

	task automatic t_supp();
		int t0;
		cmd(B_SUPP, 40'hE6);
		clr_cnt();
		align();
		t0 = cyc;
		cmd(B_EMIT, 40'h0);
		repeat (250) @(negedge clk);
		check_eq(pulses, 32'h3, "group after delay");
		check_in(first - t0, 60, 90, "delayed start");
		cmd(B_SUPP, 40'h0);
		$display("suppression test done");
	endtask

	task automatic t_cont();
		cmd(B_CNT, 40'h0);
		check_eq(group_pulse_count_q, 32'h0, "group off");
		tick_en <= 1'b0;
		repeat (3) @(negedge clk);
		clr_cnt();
		tick_en <= 1'b1;
		repeat (400) @(negedge clk);
		tick_en <= 1'b0;
		repeat (3) @(negedge clk);
		check_eq(ticks, 32'hA, "ticks sent");
		check_eq(pulses, 32'hA, "continuous");
		tick_en <= 1'b1;
		$display("continuous test done");
	endtask

	task automatic t_adjust();
		cmd(B_OFF, 40'h0);
		check_eq(emission_q, 32'h0, "emission off");
		cmd(B_ADJ, {3'h0, 1'h1, 20'h0EA60, 16'h00C8});
		repeat (2) @(negedge clk);
		check_eq(adj_result_fail_q, 32'h1, "refused adjust");
		cmd(B_CUR, 40'h28);
		cmd(B_RATE, 40'h3E8);
		check_eq(repetition_rate_setting_q, 32'h3E8, "rate setting");
		clr_cnt();
		ext_on = 1'b1;
		for (int i = 0; i < 300 && thermal_stable !== 1'b1; i++) @(negedge clk);
		cmd(B_ADJ, {3'h0, 1'h1, 20'h0EA60, 16'h00C8});
		repeat (2) @(negedge clk);
		for (int i = 0; i < 3000 && adj_busy_q !== 1'b0; i++) @(negedge clk);
		// The save pulse is counted at the edge the loop stops on, so let it land
		repeat (2) @(negedge clk);
		check_eq(adj_busy_q, 32'h0, "adjust ends");
		check_eq(adj_result_fail_q, 32'h0, "adjust ok");
		check_in(adj_result_energy_q, 184, 216, "result energy");
		check_in(adj_result_current_q, 44, 54, "result current");
		check_in(pump_current_setting_q, 44, 54, "current adopted");
		check_eq(repetition_rate_setting_q, 32'hEA60, "rate adopted");
		check_eq(saves, 32'h1, "save pulse");
		// External triggering: a good result must not replace current or rate
		int_trig = 1'b0;
		cmd(B_CUR, 40'h28);
		cmd(B_ADJ, {3'h0, 1'h0, 20'h003E8, 16'h00C8});
		repeat (2) @(negedge clk);
		for (int i = 0; i < 3000 && adj_busy_q !== 1'b0; i++) @(negedge clk);
		repeat (2) @(negedge clk);
		check_eq(adj_result_fail_q, 32'h0, "external adjust ok");
		check_eq(pump_current_setting_q, 32'h28, "current kept");
		check_eq(repetition_rate_setting_q, 32'hEA60, "rate kept");
		check_eq(saves, 32'h1, "no save asked");
		$display("adjust test done");
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Main sequence after 20 cycles of reset
	initial begin
		repeat (20) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		t_settings();
		t_group();
		t_analog();
		t_supp();
		t_cont();
		t_adjust();
		give_verdict();
	end
	// Watchdog well beyond the few thousand cycles the tests need
	initial begin
		#100000;
		err_total++;
		give_verdict();
	end
endmodule
`default_nettype wire
